// ===== testbench/sbra_spi_master.sv
// spi master model standing at the far side of the burst register port
`timescale 1ns/1ps
module sbra_spi_master (
    // clock for the released-line model
    input  wire logic ref_clk,
    // spi pins
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    input  wire logic spi_miso_o,
    input  wire logic spi_miso_oe
);
    logic [15:0] tx [0:15];
    logic [15:0] rx [0:15];
    logic        last_r;
    logic        miso_w;

    ////////////////////////////////////////////////////////////////////////////
    // released miso shows the inverse of its last driven level
    always @(posedge ref_clk) begin
        if (spi_miso_oe)
            last_r <= spi_miso_o;
    end
    assign miso_w = spi_miso_oe ? spi_miso_o : ~last_r;

    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
        last_r   = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // whole words first, then loose bits; clock idles low between frames
    task automatic frame(input int nw, input int extra);
        int b;
        spi_cs_n = 1'b0;
        #160;
        for (b = 0; b < nw * 16 + extra; b++) begin
            spi_mosi = tx[b / 16][15 - b % 16];
            #40;
            spi_sclk = 1'b1;
            rx[b / 16][15 - b % 16] = miso_w;
            #40;
            spi_sclk = 1'b0;
        end
        spi_mosi = ~spi_mosi;
        #50;
        spi_cs_n = 1'b1;
        #450;
    endtask : frame
endmodule : sbra_spi_master

// ===== testbench/sbra_top_test.sv
// self-checking bench of the burst register access port
`timescale 1ns/1ps
module sbra_top_test;
    import sbra_pkg::*;
    logic        ref_clk, sys_rst, spi_sclk, spi_cs_n, spi_mosi, spi_miso_o, spi_miso_oe;
    logic [7:0]  rd_addr, wr_addr;
    logic [14:0] rd_data, wr_data;
    logic        rd_addr_ok, wr_valid, wr_ready, transfer_failure_flag, stall, flag_e;
    logic [14:0] regs [0:255];
    logic [14:0] exp_r [0:255];
    int          mismatches, checks_done, n;

    sbra_top i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe), .chip_addr_strap(1'b0),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_addr_ok(rd_addr_ok), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .transfer_failure_flag(transfer_failure_flag));
    sbra_spi_master i_master (.ref_clk(ref_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe));

    ////////////////////////////////////////////////////////////////////////////
    // register file: 0x33 and 0xf0 upward do not exist
    function automatic logic ok(input logic [7:0] x);
        return x < 8'hF0 && x != 8'h33;
    endfunction : ok
    function automatic logic [15:0] pw(input logic [15:0] w, input int pos);
        return w | (16'(~^w) << pos);
    endfunction : pw
    assign rd_addr_ok = ok(rd_addr);
    assign rd_data    = regs[rd_addr];
    always @(posedge ref_clk) begin
        if (wr_valid && wr_ready)
            regs[wr_addr] <= wr_data;
    end
    always @(negedge ref_clk) begin
        wr_ready <= stall ? 1'b0 : 1'($urandom % 2);
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////
    // one frame: build words, work out answers, flag and register contents
    task automatic run(input logic rw, input logic mon, input logic [7:0] a, input int nw, input int extra,
                       input int bad, input logic cok);
        logic [15:0] ex [0:15];
        logic [14:0] d;
        logic [7:0]  ad;
        logic        fail, rej;
        int          i, pushes;
        fail = !ok(a) || extra != 0 || (mon && nw % 2 == 0);
        rej = !ok(a) || !cok;
        pushes = 0;
        i_master.tx[0] = pw({1'b1, !cok, rw, mon, a, 4'h0}, 0);
        for (i = 0; i < nw; i++) begin
            d = 15'($urandom);
            ad = mon ? a : a + 8'(i);
            i_master.tx[i + 1] = pw({1'b0, d}, 15) ^ (i == bad ? 16'h8000 : 16'h0000);
            ex[i] = (rej || i >= bad || !ok(ad)) ? 16'hFFFF : pw({1'b0, exp_r[ad]}, 15);
            if (i == bad)
                fail = 1'b1;
            if (!rej && i < bad && ok(ad) && rw) begin
                if (!mon && stall && pushes == 8)
                    fail = 1'b1;
                else if (!mon) begin
                    exp_r[ad] = d;
                    pushes++;
                end else if (i == nw - 1 && nw % 2 == 1)
                    exp_r[ad] = d;
            end
        end
        i_master.tx[nw + 1] = 16'($urandom);
        @(negedge ref_clk);
        i_master.frame(nw + 1, extra);
        if (cok)
            chk({2'b00, i_master.rx[0][13:0]}, {2'b00, 5'b10101, flag_e, a});
        for (i = 0; i < nw; i++)
            if (i != bad)
                chk(i_master.rx[i + 1], ex[i]);
        if (cok)
            flag_e = fail;
        repeat (20) @(negedge ref_clk);
        chk({15'h0000, transfer_failure_flag}, {15'h0000, flag_e});
        stall = 1'b0;
        for (i = 0; i < 200 && wr_valid !== 1'b0; i++)
            @(negedge ref_clk);
        for (i = 0; i < nw + 1; i++)
            chk({1'b0, regs[a + 8'(i)]}, {1'b0, exp_r[a + 8'(i)]});
    endtask : run

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        #400000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        sys_rst = 1'b1;
        stall = 1'b0;
        flag_e = 1'b0;
        wr_ready = 1'b0;
        mismatches = 0;
        checks_done = 0;
        void'($urandom(32'h283c));
        for (n = 0; n < 256; n++) begin
            regs[n] = 15'($urandom);
            exp_r[n] = regs[n];
        end
        repeat (4) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (8) @(negedge ref_clk);
        run(1'b1, 1'b0, 8'h10, 3, 0, 99, 1'b1);
        run(1'b0, 1'b0, 8'h10, 3, 0, 99, 1'b1);
        run(1'b1, 1'b0, 8'h31, 4, 0, 99, 1'b1);
        run(1'b1, 1'b0, 8'h20, 3, 5, 99, 1'b1);
        run(1'b1, 1'b0, 8'h40, 4, 0, 1, 1'b1);
        run(1'b1, 1'b0, 8'hF5, 2, 0, 99, 1'b1);
        run(1'b1, 1'b1, 8'h50, 3, 0, 99, 1'b1);
        run(1'b1, 1'b1, 8'h51, 2, 0, 99, 1'b1);
        run(1'b0, 1'b0, 8'h10, 1, 0, 99, 1'b0);
        stall = 1'b1;
        repeat (2) @(negedge ref_clk);
        run(1'b1, 1'b0, 8'h60, 10, 0, 99, 1'b1);
        run(1'b0, 1'b0, 8'h60, 10, 0, 99, 1'b1);
        for (n = 0; n < 12; n++)
            run(1'($urandom), 1'b0, 8'($urandom % 224), 1 + $urandom % 6, 0, 99, 1'b1);
        report_and_stop();
    end
endmodule : sbra_top_test

// ===== verilog/sbra_fifo.sv
// write fifo between the link and the register side
`timescale 1ns/1ps
`include "sbra_regs.svh"
module sbra_fifo import sbra_pkg::*; #(
    parameter int W     = `SBRA_FIFO_W,
    parameter int DEPTH = `SBRA_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic  ref_clk,
    input  wire logic  sys_rst,
    // both sides
    sbra_fifo_if.fifo  q
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
    } sbra_fifo_st_t;

    sbra_fifo_st_t r_r;
    sbra_fifo_st_t r_nxt;
    logic          do_push;
    logic          do_pop;

    assign q.in_ready  = (r_r.cnt != FULL);
    assign q.out_valid = (r_r.cnt != '0);
    assign q.out_data  = r_r.mem[r_r.rp];
    assign do_push     = q.in_valid && q.in_ready;
    assign do_pop      = q.out_valid && q.out_ready;

    always_comb begin
        r_nxt = r_r;
        if (do_push) begin
            r_nxt.mem[r_r.wp] = q.in_data;
            r_nxt.wp          = AW'(r_r.wp + 1'b1);
        end
        if (do_pop) begin
            r_nxt.rp = AW'(r_r.rp + 1'b1);
        end
        case ({do_push, do_pop})
            2'b10:   r_nxt.cnt = (AW+1)'(r_r.cnt + 1'b1);
            2'b01:   r_nxt.cnt = (AW+1)'(r_r.cnt - 1'b1);
            default: r_nxt.cnt = r_r.cnt;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end
endmodule : sbra_fifo

// ===== verilog/sbra_fifo_if.sv
// carrier between the port logic and its write fifo
`timescale 1ns/1ps
interface sbra_fifo_if #(parameter int W = 23);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;

    modport fifo (input in_valid, input in_data, input out_ready,
                  output in_ready, output out_valid, output out_data);
    modport user (output in_valid, output in_data, output out_ready,
                  input in_ready, input out_valid, input out_data);
endinterface : sbra_fifo_if

// ===== verilog/sbra_pkg.sv
// types of the burst register access port
package sbra_pkg;
`include "sbra_regs.svh"

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_INSTR  = 4'h2,
        ST_DATA   = 4'h4,
        ST_REJECT = 4'h8
    } sbra_state_t;

    typedef struct packed {
        logic [3:0]                 sync1;
        logic [3:0]                 sync2;
        logic                       sclk_d;
        logic                       cs_d;
        logic [1:0]                 strap_cnt;
        logic                       strap_val;
        sbra_state_t                state;
        logic [3:0]                 bitcnt;
        logic [15:0]                sh;
        logic                       par;
        logic                       match;
        logic                       rw;
        logic                       frame_length_check_select;
        logic [`SBRA_ADDR_W-1:0]    ptr;
        logic                       chk_pend;
        logic                       ld_pend;
        logic                       err;
        logic                       odd_words;
        logic [`SBRA_DATA_W-1:0]    pend_data;
        logic [15:0]                miso_sh;
        logic                       miso;
        logic                       miso_oe;
        logic                       transfer_failure_flag;
        logic                       push_v;
        logic [`SBRA_FIFO_W-1:0]    push_d;
    } sbra_st_t;

endpackage : sbra_pkg

// ===== verilog/sbra_regs.svh
// constants of the burst register access port: field positions, widths, reset values
// Behaviour
// - one instruction word, then 16-bit data words while select low and clock runs
// - burst write stores each received word into consecutively addressed registers
// - write burst returns check word first, then previous content of each written register
// - read burst returns check word, then contents of consecutive registers
// - in burst mode, address pointer advances after every 16-clock data word while select stays low
// - in burst mode, write word is committed as soon as its 16th clock completes
// - at select release the clock count must be a whole number of words
// - complete words are latched, trailing partial word bits are dropped
// - parity error rejects that word and every later word of the burst
// - excess bits or parity error set failure flag for the next transfer
// - invalid start address invalidates whole access and sets failure flag
// - nonexistent address inside a burst is skipped silently, burst continues
// - checked write with odd count of data words executes with the last word
// - check bit low selects burst mode, high needs whole frame or discards
// - instruction and data words each carry odd parity over their 16 bits
// - first answer word: two bits high impedance, pattern 10101, flag, address echo
// - failure flag shows whether previous transfer with matching chip address failed
`ifndef SBRA_REGS_SVH
`define SBRA_REGS_SVH

// word geometry
`define SBRA_WORD_BITS    16
`define SBRA_ADDR_W       8
`define SBRA_DATA_W       15
`define SBRA_FIFO_W       23
`define SBRA_FIFO_DEPTH   8

// instruction word field positions (bit 31 of frame is bit 15 here)
`define SBRA_IN_CHIP_HI   15
`define SBRA_IN_CHIP_LO   14
`define SBRA_IN_RW        13
`define SBRA_IN_MON       12
`define SBRA_IN_ADDR_HI   11
`define SBRA_IN_ADDR_LO   4

// pin synchroniser lanes
`define SBRA_P_SCLK       0
`define SBRA_P_CS         1
`define SBRA_P_MOSI       2
`define SBRA_P_STRAP      3

// answer values and reset values
`define SBRA_LAST_BIT     4'h0F
`define SBRA_FLAG_BIT     4'h07
`define SBRA_PAT_FIRST    4'h02
`define SBRA_PAT_LAST     4'h06
`define SBRA_ECHO_TAP     3
`define SBRA_BAD_WORD     16'hFFFF
`define SBRA_FLAG_RST     1'b0
`define SBRA_STRAP_WAIT   2'h3

`endif

// ===== verilog/sbra_top.sv
// burst register access port: spi slave front end with write fifo
`timescale 1ns/1ps
`include "sbra_regs.svh"
module sbra_top import sbra_pkg::*; (
    // clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    // spi pins
    input  wire logic                     spi_sclk,
    input  wire logic                     spi_cs_n,
    input  wire logic                     spi_mosi,
    output logic                          spi_miso_o,
    output logic                          spi_miso_oe,
    // chip address strap
    input  wire logic                     chip_addr_strap,
    // register read side
    output logic [`SBRA_ADDR_W-1:0]       rd_addr,
    input  wire logic [`SBRA_DATA_W-1:0]  rd_data,
    input  wire logic                     rd_addr_ok,
    // register write side
    output logic                          wr_valid,
    input  wire logic                     wr_ready,
    output logic [`SBRA_ADDR_W-1:0]       wr_addr,
    output logic [`SBRA_DATA_W-1:0]       wr_data,
    // status
    output logic                          transfer_failure_flag
);
    // select lane resets to its idle high level, so no false frame edge follows reset
    localparam sbra_st_t RST_VAL = '{state: ST_IDLE, cs_d: 1'b1, sync1: 4'h2, sync2: 4'h2, default: '0};

    sbra_st_t    r_r;
    sbra_st_t    r_nxt;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_fall;
    logic        cs_rise;
    logic        mosi_bit;
    logic [15:0] word;
    logic        podd;
    logic        word_end;
    logic        bad;

    sbra_fifo_if #(.W(`SBRA_FIFO_W)) q ();

    sbra_fifo #(.W(`SBRA_FIFO_W), .DEPTH(`SBRA_FIFO_DEPTH)) u_fifo (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .q       (q.fifo)
    );

    ////////////////////////////////////////////////////////////////////////
    // edges of the synchronised pins
    assign sclk_rise = r_r.sync2[`SBRA_P_SCLK] && !r_r.sclk_d;
    assign sclk_fall = !r_r.sync2[`SBRA_P_SCLK] && r_r.sclk_d;
    assign cs_fall   = !r_r.sync2[`SBRA_P_CS] && r_r.cs_d;
    assign cs_rise   = r_r.sync2[`SBRA_P_CS] && !r_r.cs_d;
    assign mosi_bit  = r_r.sync2[`SBRA_P_MOSI];
    assign word      = {r_r.sh[14:0], mosi_bit};
    assign podd      = r_r.par ^ mosi_bit;
    assign word_end  = sclk_rise && (r_r.bitcnt == `SBRA_LAST_BIT);

    // fifo and outputs
    assign q.in_valid            = r_r.push_v;
    assign q.in_data             = r_r.push_d;
    assign q.out_ready           = wr_ready;
    assign wr_valid              = q.out_valid;
    assign wr_addr               = q.out_data[`SBRA_FIFO_W-1:`SBRA_DATA_W];
    assign wr_data               = q.out_data[`SBRA_DATA_W-1:0];
    assign spi_miso_o            = r_r.miso;
    assign spi_miso_oe           = r_r.miso_oe;
    assign rd_addr               = r_r.ptr;
    assign transfer_failure_flag = r_r.transfer_failure_flag;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        r_nxt          = r_r;
        bad            = 1'b0;
        r_nxt.sync1    = {chip_addr_strap, spi_mosi, spi_cs_n, spi_sclk};
        r_nxt.sync2    = r_r.sync1;
        r_nxt.sclk_d   = r_r.sync2[`SBRA_P_SCLK];
        r_nxt.cs_d     = r_r.sync2[`SBRA_P_CS];
        r_nxt.push_v   = 1'b0;
        r_nxt.chk_pend = 1'b0;
        r_nxt.ld_pend  = 1'b0;
        // strap caught once the synchroniser holds a real value
        if (r_r.strap_cnt != `SBRA_STRAP_WAIT) begin
            r_nxt.strap_cnt = 2'(r_r.strap_cnt + 1'b1);
            r_nxt.strap_val = r_r.sync2[`SBRA_P_STRAP];
        end
        if (cs_fall) begin
            r_nxt.state     = ST_INSTR;
            r_nxt.bitcnt    = '0;
            r_nxt.par       = 1'b0;
            r_nxt.match     = 1'b0;
            r_nxt.err       = 1'b0;
            r_nxt.odd_words = 1'b0;
            r_nxt.ptr       = '0;
            r_nxt.miso      = 1'b0;
            r_nxt.miso_oe   = 1'b0;
        end else if (cs_rise) begin
            if (r_r.match) begin
                // partial word, unfinished instruction or earlier error
                bad = r_r.err || (r_r.bitcnt != '0) || (r_r.state != ST_DATA);
                if (r_r.frame_length_check_select && !r_r.odd_words) begin
                    bad = 1'b1;
                end
                if (!bad && r_r.frame_length_check_select && r_r.rw && rd_addr_ok) begin
                    if (q.in_ready) begin
                        r_nxt.push_v = 1'b1;
                        r_nxt.push_d = {r_r.ptr, r_r.pend_data};
                    end else begin
                        bad = 1'b1;
                    end
                end
                r_nxt.transfer_failure_flag = bad;
            end
            r_nxt.state   = ST_IDLE;
            r_nxt.miso_oe = 1'b0;
        end else if (r_r.state != ST_IDLE) begin
            if (sclk_rise) begin
                r_nxt.sh     = word;
                r_nxt.bitcnt = 4'(r_r.bitcnt + 1'b1);
                r_nxt.par    = podd;
                if (r_r.state == ST_INSTR && r_r.bitcnt == 4'h1) begin
                    r_nxt.match = word[1] && (word[0] == r_r.strap_val);
                end
                if (word_end) begin
                    r_nxt.par     = 1'b0;
                    r_nxt.ld_pend = 1'b1;
                    case (r_r.state)
                        ST_INSTR: begin
                            r_nxt.rw                        = word[`SBRA_IN_RW];
                            r_nxt.frame_length_check_select = word[`SBRA_IN_MON];
                            r_nxt.ptr = word[`SBRA_IN_ADDR_HI:`SBRA_IN_ADDR_LO];
                            if (!podd || !r_r.match) begin
                                r_nxt.state = ST_REJECT;
                                r_nxt.err   = 1'b1;
                            end else begin
                                r_nxt.state    = ST_DATA;
                                r_nxt.chk_pend = 1'b1;
                            end
                        end
                        ST_DATA: begin
                            if (!podd) begin
                                r_nxt.state = ST_REJECT;
                                r_nxt.err   = 1'b1;
                            end else if (r_r.frame_length_check_select) begin
                                r_nxt.odd_words = !r_r.odd_words;
                                r_nxt.pend_data = word[`SBRA_DATA_W-1:0];
                            end else begin
                                if (r_r.rw && rd_addr_ok) begin
                                    if (q.in_ready) begin
                                        r_nxt.push_v = 1'b1;
                                        r_nxt.push_d = {r_r.ptr, word[`SBRA_DATA_W-1:0]};
                                    end else begin
                                        r_nxt.err = 1'b1;
                                    end
                                end
                                r_nxt.ptr = 8'(r_r.ptr + 1'b1);
                            end
                        end
                        default: begin
                            r_nxt.state = ST_REJECT;
                        end
                    endcase
                end
            end else if (sclk_fall) begin
                if (r_r.state == ST_INSTR) begin
                    r_nxt.miso_oe = (r_r.bitcnt >= `SBRA_PAT_FIRST);
                    if (r_r.bitcnt <= `SBRA_PAT_LAST) begin
                        r_nxt.miso = !r_r.bitcnt[0];
                    end else if (r_r.bitcnt == `SBRA_FLAG_BIT) begin
                        r_nxt.miso = r_r.transfer_failure_flag;
                    end else begin
                        r_nxt.miso = r_r.sh[`SBRA_ECHO_TAP];
                    end
                end else begin
                    r_nxt.miso_oe = 1'b1;
                    r_nxt.miso    = r_r.miso_sh[4'(4'hF - r_r.bitcnt)];
                end
            end
            if (r_r.chk_pend && !rd_addr_ok) begin
                r_nxt.state = ST_REJECT;
                r_nxt.err   = 1'b1;
            end
            if (r_r.ld_pend) begin
                // old content is what a write answers with
                if (r_r.state == ST_DATA && rd_addr_ok) begin
                    r_nxt.miso_sh = {~^rd_data, rd_data};
                end else begin
                    r_nxt.miso_sh = `SBRA_BAD_WORD;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_r <= RST_VAL;
        end else begin
            r_r <= r_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    frame_start_a: assert property (cs_fall |=> !spi_miso_oe && r_r.bitcnt == '0 && r_r.state == ST_INSTR)
        else $error("frame start did not clear the port state");
    check_pattern_a: assert property (sclk_fall && r_r.state == ST_INSTR && r_r.bitcnt == 4'h2
                                      |=> spi_miso_oe && spi_miso_o)
        else $error("check pattern first bit wrong");
    flag_answer_a: assert property (sclk_fall && r_r.state == ST_INSTR && r_r.bitcnt == `SBRA_FLAG_BIT
                                    |=> spi_miso_o == $past(r_r.transfer_failure_flag))
        else $error("failure flag bit not answered");
    ptr_step_a: assert property (word_end && r_r.state == ST_DATA && podd && !r_r.frame_length_check_select
                                 |=> r_r.ptr == 8'($past(r_r.ptr) + 1'b1))
        else $error("pointer did not advance after a word");
    write_commit_a: assert property (word_end && r_r.state == ST_DATA && podd && r_r.rw && rd_addr_ok
                                     && !r_r.frame_length_check_select && q.in_ready
                                     |=> r_r.push_v && r_r.push_d[`SBRA_FIFO_W-1:`SBRA_DATA_W] == $past(r_r.ptr))
        else $error("write word not committed at word end");
    reject_hold_a: assert property (r_r.state == ST_REJECT && !cs_rise |=> r_r.state == ST_REJECT && !r_r.push_v)
        else $error("rejected burst resumed");
    parity_reject_a: assert property (word_end && r_r.state == ST_DATA && !podd |=> r_r.state == ST_REJECT && r_r.err)
        else $error("bad parity word not rejected");
    trail_flag_a: assert property (cs_rise && r_r.match && r_r.bitcnt != '0 |=> transfer_failure_flag)
        else $error("partial word did not raise failure flag");
    bad_start_a: assert property (r_r.chk_pend && !rd_addr_ok && !cs_rise |=> r_r.state == ST_REJECT)
        else $error("invalid start address accepted");
    skip_addr_a: assert property (word_end && r_r.state == ST_DATA && podd && !rd_addr_ok
                                  && !r_r.frame_length_check_select |=> r_r.state == ST_DATA && !r_r.push_v)
        else $error("missing register did not skip cleanly");
    checked_write_a: assert property (cs_rise && r_r.match && r_r.state == ST_DATA && !r_r.err && r_r.bitcnt == '0
                                      && r_r.frame_length_check_select && r_r.odd_words && r_r.rw
                                      && rd_addr_ok && q.in_ready |=> r_r.push_v && !transfer_failure_flag)
        else $error("checked write with odd word count not executed");
endmodule : sbra_top
